// >>> dv/aefa_axis_enable_ctrl_chk.sv
module aefa_axis_enable_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Drive and axis
  input wire logic driveEnable,
  input wire logic driveReady,
  input wire logic axisAtRest,
  input wire logic opFaultEvent,
  input wire logic cfgFaultCause,
  input wire logic brakeRequest,
  input wire logic jerkLimit,
  input wire logic pulseHalt,
  input wire logic axisEnabledFlag,
  input wire logic axisFaultFlag,
  input wire logic [1:0] stopBehaviourSelect,
  input wire logic [31:0] workConfig
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rest_seen;
    brakeRequest && axisAtRest;
  endsequence
  sequence s_off;
    !axisEnabledFlag && !driveEnable && pulseHalt;
  endsequence
  chk_on_after_ready: assert property (
    $rose(axisEnabledFlag) && driveEnable |-> $past(driveReady))
    else $error("axis enabled without drive ready");
  chk_on_not_halted: assert property (
    axisEnabledFlag |-> !pulseHalt) else $error("pulses halted while on");
  chk_jerk_sel: assert property (
    jerkLimit == (brakeRequest &&
      stopBehaviourSelect == aefa_pkg::STOP_EMERG_JERK))
    else $error("jerk limit wrong");
  chk_brake_enabled: assert property (
    brakeRequest |-> axisEnabledFlag) else $error("flag low while braking");
  chk_stop_rest: assert property (
    s_rest_seen |=> s_off) else $error("not off after standstill");
  chk_stop_now: assert property (
    brakeRequest && stopBehaviourSelect == aefa_pkg::STOP_IMMEDIATE
    |=> s_off) else $error("immediate stop late");
  chk_fault_latch: assert property (
    opFaultEvent || cfgFaultCause |=> axisFaultFlag)
    else $error("fault not latched");
  chk_work_cfg: assert property (
    $changed(workConfig) |-> $past(pulseHalt))
    else $error("config copied while enabled");
  chk_off_no_drive: assert property (
    $fell(axisEnabledFlag) |-> !driveEnable)
    else $error("drive enabled after disable");
endmodule // aefa_axis_enable_ctrl_chk

bind aefa_axis_enable_ctrl aefa_axis_enable_ctrl_chk chk_inst (
  .clk(clk), .reset(reset), .driveEnable(driveEnable),
  .driveReady(driveReady), .axisAtRest(axisAtRest),
  .opFaultEvent(opFaultEvent), .cfgFaultCause(cfgFaultCause),
  .brakeRequest(brakeRequest), .jerkLimit(jerkLimit),
  .pulseHalt(pulseHalt), .axisEnabledFlag(axisEnabledFlag),
  .axisFaultFlag(axisFaultFlag),
  .stopBehaviourSelect(stopBehaviourSelect), .workConfig(workConfig));

// >>> dv/aefa_drive_model.sv
module aefa_drive_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Drive link
  input wire logic driveEnable,
  input wire logic [3:0] readyDelay,
  output logic driveReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // Settling time counts only while power is applied
  always_comb begin
    cnt_nxt = driveEnable ? cnt_r : 4'h0;
    if (driveEnable && cnt_r != readyDelay) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // Ready only after power has settled, lost at once with power
  assign driveReady = driveEnable && cnt_r == readyDelay;
endmodule // aefa_drive_model

// >>> dv/tb_aefa_axis_enable_ctrl.sv
module tb_aefa_axis_enable_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, rdErr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, workConfig;
  logic driveEnable, driveReady, axisAtRest, opFaultEvent, cfgFaultCause;
  logic brakeRequest, jerkLimit, pulseHalt, axisEnabledFlag, axisFaultFlag;
  logic [1:0] stopBehaviourSelect;
  logic [3:0] readyDelay;
  int err_count, compares;
  aefa_axis_enable_ctrl aefa_axis_enable_ctrl_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .driveEnable(driveEnable),
    .driveReady(driveReady), .axisAtRest(axisAtRest),
    .opFaultEvent(opFaultEvent), .cfgFaultCause(cfgFaultCause),
    .brakeRequest(brakeRequest), .jerkLimit(jerkLimit),
    .pulseHalt(pulseHalt), .axisEnabledFlag(axisEnabledFlag),
    .axisFaultFlag(axisFaultFlag),
    .stopBehaviourSelect(stopBehaviourSelect), .workConfig(workConfig),
    .irq(irq));
  aefa_drive_model aefa_drive_model_inst (
    .clk(clk), .reset(reset), .driveEnable(driveEnable),
    .readyDelay(readyDelay), .driveReady(driveReady));
  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic checkb(input string name, input logic seen, exp);
    check(name, 32'(seen), 32'(exp));
  endtask
  // One APB transfer, released at the answer edge, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitSt(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, aefa_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 40);
    if (rd[b] !== v) begin
      err_count++;
      conclude();
    end
  endtask
  function automatic logic [31:0] ctl(int en, int st, int dv, int rl,
                                      int ln);
    ctl = 32'h0;
    ctl[aefa_pkg::CTRL_ENABLE] = 1'(en);
    ctl[aefa_pkg::CTRL_STOP_LSB +: 2] = 2'(st);
    ctl[aefa_pkg::CTRL_DRIVE_IF] = 1'(dv);
    ctl[aefa_pkg::CTRL_RELOAD] = 1'(rl);
    ctl[aefa_pkg::CTRL_LAUNCH] = 1'(ln);
  endfunction
  // Launch a task from a clear trigger, then wait for it to finish
  task automatic runAck(input logic [31:0] base);
    apb(1'b1, aefa_pkg::OFF_CTRL, base);
    apb(1'b1, aefa_pkg::OFF_CTRL, base | ctl(0, 0, 0, 0, 1));
    apb(1'b0, aefa_pkg::OFF_STATUS, 32'h0);
    checkb("ack busy", rd[aefa_pkg::ST_ACK_BUSY], 1'b1);
    waitSt(aefa_pkg::ST_ACK_BUSY, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {opFaultEvent, cfgFaultCause} = 2'h0;
    axisAtRest = 1'b1;
    readyDelay = 4'h8;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, aefa_pkg::OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    checkb("unmapped", rdErr, 1'b1);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, aefa_pkg::OFF_CTRL, ctl(1, 2'(s), s == 0, 0, 0));
      apb(1'b0, aefa_pkg::OFF_STATUS, 32'h0);
      checkb("drive en", rd[aefa_pkg::ST_DRIVE_EN], s == 0);
      checkb("enabled", rd[aefa_pkg::ST_ENABLED], s != 0);
      waitSt(aefa_pkg::ST_ENABLED, 1'b1);
      check("stop sel", 32'(stopBehaviourSelect), 32'(s));
      if (s == 0) begin
        checkb("irq masked", irq, 1'b0);
        apb(1'b1, aefa_pkg::OFF_IRQ_MASK, 32'h1F);
        checkb("irq on", irq, 1'b1);
        apb(1'b1, aefa_pkg::OFF_IRQ_STAT, 32'h1F);
        checkb("irq clear", irq, 1'b0);
        apb(1'b1, aefa_pkg::OFF_IRQ_MASK, 32'h0);
      end
      axisAtRest <= 1'b0;
      apb(1'b0, aefa_pkg::OFF_STATUS, 32'h0);
      checkb("moving", rd[aefa_pkg::ST_AT_REST], 1'b0);
      axisAtRest <= 1'b1;
      waitSt(aefa_pkg::ST_AT_REST, 1'b1);
      apb(1'b1, aefa_pkg::OFF_CTRL, ctl(0, 2'(s), s == 0, 0, 0));
      @(negedge clk);
      checkb("still on", axisEnabledFlag, s != 1);
      checkb("brake", brakeRequest, s != 1);
      checkb("halt", pulseHalt, s == 1);
      checkb("jerk", jerkLimit, s == 2);
      @(posedge clk);
      waitSt(aefa_pkg::ST_ENABLED, 1'b0);
      checkb("busy off", rd[aefa_pkg::ST_BUSY], 1'b0);
      checkb("drive off", driveEnable, 1'b0);
    end
    apb(1'b1, aefa_pkg::OFF_LOAD_CFG, 32'hA5C3_1E27);
    runAck(ctl(0, 0, 0, 1, 0));
    checkb("reload done", rd[aefa_pkg::ST_ACK_DONE], 1'b1);
    check("work cfg", workConfig, 32'hA5C3_1E27);
    apb(1'b1, aefa_pkg::OFF_LOAD_CFG, 32'h1234_5678);
    apb(1'b1, aefa_pkg::OFF_CTRL, ctl(0, 0, 0, 1, 1));
    apb(1'b0, aefa_pkg::OFF_STATUS, 32'h0);
    checkb("held launch", rd[aefa_pkg::ST_ACK_BUSY], 1'b0);
    apb(1'b1, aefa_pkg::OFF_CTRL, ctl(1, 0, 0, 0, 0));
    runAck(ctl(1, 0, 0, 1, 0));
    checkb("reload err", rd[aefa_pkg::ST_ACK_ERROR], 1'b1);
    checkb("kept on", axisEnabledFlag, 1'b1);
    check("work kept", workConfig, 32'hA5C3_1E27);
    apb(1'b0, aefa_pkg::OFF_FAULT, 32'h0);
    check("code", rd, {aefa_pkg::DETAIL_RELOAD,
                       aefa_pkg::CODE_NOT_DISABLED});
    apb(1'b1, aefa_pkg::OFF_CTRL, ctl(0, 1, 0, 0, 0));
    opFaultEvent <= 1'b1;
    cfgFaultCause <= 1'b1;
    @(posedge clk);
    opFaultEvent <= 1'b0;
    @(posedge clk);
    checkb("fault set", axisFaultFlag, 1'b1);
    runAck(ctl(0, 1, 0, 0, 0));
    checkb("cause err", rd[aefa_pkg::ST_ACK_ERROR], 1'b1);
    apb(1'b0, aefa_pkg::OFF_FAULT, 32'h0);
    check("code", rd, {aefa_pkg::DETAIL_CFG_CAUSE,
                       aefa_pkg::CODE_CAUSE_PRESENT});
    cfgFaultCause <= 1'b0;
    runAck(ctl(0, 1, 0, 0, 0));
    checkb("ack done", rd[aefa_pkg::ST_ACK_DONE], 1'b1);
    checkb("fault flag", axisFaultFlag, 1'b0);
    check("latches", 32'(rd[9:8]), 32'h0);
    conclude();
  end
endmodule // tb_aefa_axis_enable_ctrl

// >>> hw/aefa_axis_enable_ctrl.sv
// Function
// - With drive interface, enable request raises drive enable, then waits for ready.
// - Drive ready marks axis enabled; status and enabled flag read true.
// - Without drive interface, enable request enables the axis at once.
// - Disabling ends only when busy, status and enabled flag are false.
// - Acknowledge or reload task starts only on a rising launch edge.
// - Acknowledge task is not aborted and aborts no other task.
// - Reload copies load configuration to working configuration, only when disabled.
// - Without reload, the task acknowledges pending axis faults.
// - Done rises when fault is cleared; fault flag then reads false.
// - Acknowledge busy stays true while the task executes.
// - A failed task raises error with 16-bit fault code and detail.
// - Acknowledge clears both operating and configuration fault latches.
// - Stop select: 0 emergency brake, 1 immediate off, 2 brake with jerk.
module aefa_axis_enable_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive side
  output logic driveEnable,
  input wire logic driveReady,
  // Axis motion side
  input wire logic axisAtRest,
  input wire logic opFaultEvent,
  input wire logic cfgFaultCause,
  output logic brakeRequest,
  output logic jerkLimit,
  output logic pulseHalt,
  output logic axisEnabledFlag,
  output logic axisFaultFlag,
  output logic [1:0] stopBehaviourSelect,
  output logic [31:0] workConfig,
  // Interrupt
  output logic irq
);

  logic [aefa_pkg::CTRL_WIDTH-1:0] ctrl_r, ctrl_nxt;
  logic [31:0] loadCfg_r, loadCfg_nxt;
  logic [31:0] workCfg_r, workCfg_nxt;
  logic launchPrev_r, launchPrev_nxt;
  aefa_pkg::aefa_pwr_t pwr_r, pwr_nxt;
  aefa_pkg::aefa_ack_t ack_r, ack_nxt;
  logic [3:0] ackCnt_r, ackCnt_nxt;
  logic ackDone_r, ackDone_nxt;
  logic ackError_r, ackError_nxt;
  logic [15:0] faultCode_r, faultCode_nxt;
  logic [15:0] faultDetail_r, faultDetail_nxt;
  logic opFault_r, opFault_nxt;
  logic cfgFault_r, cfgFault_nxt;
  logic [aefa_pkg::IRQ_WIDTH-1:0] irqStat_r, irqStat_nxt;
  logic [aefa_pkg::IRQ_WIDTH-1:0] irqMask_r, irqMask_nxt;
  logic [aefa_pkg::IRQ_WIDTH-1:0] irqEvent;

  logic wrStrobe;
  logic enableReq;
  logic driveIfCfg;
  logic reloadSel;
  logic launch;
  logic launchRise;
  logic [1:0] stopSel;
  logic statusOn;
  logic pwrBusy;
  logic ackBusy;
  logic ackFinishOk;
  logic ackFinishErr;
  logic clearFaults;
  logic doCopy;
  logic [15:0] statusWord;

  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] off);
    regHit = (addr == off);
  endfunction

  // Bus access
  assign wrStrobe = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(
    regHit(paddr, aefa_pkg::OFF_CTRL) ||
    regHit(paddr, aefa_pkg::OFF_STATUS) ||
    regHit(paddr, aefa_pkg::OFF_FAULT) ||
    regHit(paddr, aefa_pkg::OFF_IRQ_STAT) ||
    regHit(paddr, aefa_pkg::OFF_IRQ_MASK) ||
    regHit(paddr, aefa_pkg::OFF_LOAD_CFG) ||
    regHit(paddr, aefa_pkg::OFF_WORK_CFG));

  assign enableReq = ctrl_r[aefa_pkg::CTRL_ENABLE];
  assign driveIfCfg = ctrl_r[aefa_pkg::CTRL_DRIVE_IF];
  assign reloadSel = ctrl_r[aefa_pkg::CTRL_RELOAD];
  assign launch = ctrl_r[aefa_pkg::CTRL_LAUNCH];
  assign stopSel = ctrl_r[aefa_pkg::CTRL_STOP_LSB +: 2];
  assign launchRise = launch && !launchPrev_r;

  // Status word
  always_comb begin
    statusWord = 16'h0000;
    statusWord[aefa_pkg::ST_ENABLED] = statusOn;
    statusWord[aefa_pkg::ST_BUSY] = pwrBusy;
    statusWord[aefa_pkg::ST_AT_REST] = axisAtRest;
    statusWord[aefa_pkg::ST_FAULT] = axisFaultFlag;
    statusWord[aefa_pkg::ST_ACK_BUSY] = ackBusy;
    statusWord[aefa_pkg::ST_ACK_DONE] = ackDone_r;
    statusWord[aefa_pkg::ST_ACK_ERROR] = ackError_r;
    statusWord[aefa_pkg::ST_DRIVE_EN] = driveEnable;
    statusWord[aefa_pkg::ST_OP_FAULT] = opFault_r;
    statusWord[aefa_pkg::ST_CFG_FAULT] = cfgFault_r;
  end

  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (regHit(paddr, aefa_pkg::OFF_CTRL)) begin
      prdata[aefa_pkg::CTRL_WIDTH-1:0] = ctrl_r;
    end else if (regHit(paddr, aefa_pkg::OFF_STATUS)) begin
      prdata[15:0] = statusWord;
    end else if (regHit(paddr, aefa_pkg::OFF_FAULT)) begin
      prdata = {faultDetail_r, faultCode_r};
    end else if (regHit(paddr, aefa_pkg::OFF_IRQ_STAT)) begin
      prdata[aefa_pkg::IRQ_WIDTH-1:0] = irqStat_r;
    end else if (regHit(paddr, aefa_pkg::OFF_IRQ_MASK)) begin
      prdata[aefa_pkg::IRQ_WIDTH-1:0] = irqMask_r;
    end else if (regHit(paddr, aefa_pkg::OFF_LOAD_CFG)) begin
      prdata = loadCfg_r;
    end else if (regHit(paddr, aefa_pkg::OFF_WORK_CFG)) begin
      prdata = workCfg_r;
    end
  end

  // Software registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    loadCfg_nxt = loadCfg_r;
    irqMask_nxt = irqMask_r;
    launchPrev_nxt = launch;
    if (wrStrobe && regHit(paddr, aefa_pkg::OFF_CTRL)) begin
      ctrl_nxt = pwdata[aefa_pkg::CTRL_WIDTH-1:0];
    end
    if (wrStrobe && regHit(paddr, aefa_pkg::OFF_LOAD_CFG)) begin
      loadCfg_nxt = pwdata;
    end
    if (wrStrobe && regHit(paddr, aefa_pkg::OFF_IRQ_MASK)) begin
      irqMask_nxt = pwdata[aefa_pkg::IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= aefa_pkg::CTRL_RESET;
      loadCfg_r <= aefa_pkg::CFG_RESET;
      irqMask_r <= aefa_pkg::IRQ_MASK_RESET;
      launchPrev_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      loadCfg_r <= loadCfg_nxt;
      irqMask_r <= irqMask_nxt;
      launchPrev_r <= launchPrev_nxt;
    end
  end

  // Axis enable control
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      aefa_pkg::PWR_OFF: begin
        if (enableReq && !axisFaultFlag) begin
          if (driveIfCfg) begin
            pwr_nxt = aefa_pkg::PWR_WAIT_READY;
          end else begin
            pwr_nxt = aefa_pkg::PWR_ON;
          end
        end
      end
      aefa_pkg::PWR_WAIT_READY: begin
        if (!enableReq || opFault_r) begin
          pwr_nxt = aefa_pkg::PWR_OFF;
        end else if (driveReady) begin
          pwr_nxt = aefa_pkg::PWR_ON;
        end
      end
      aefa_pkg::PWR_ON: begin
        if (!enableReq || opFault_r || (driveIfCfg && !driveReady)) begin
          if (stopSel == aefa_pkg::STOP_IMMEDIATE) begin
            pwr_nxt = aefa_pkg::PWR_OFF;
          end else begin
            pwr_nxt = aefa_pkg::PWR_STOPPING;
          end
        end
      end
      aefa_pkg::PWR_STOPPING: begin
        if (stopSel == aefa_pkg::STOP_IMMEDIATE) begin
          pwr_nxt = aefa_pkg::PWR_OFF;
        end else if (axisAtRest) begin
          pwr_nxt = aefa_pkg::PWR_OFF;
        end
      end
      default: pwr_nxt = aefa_pkg::PWR_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_r <= aefa_pkg::PWR_OFF;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  assign statusOn = (pwr_r == aefa_pkg::PWR_ON) ||
                    (pwr_r == aefa_pkg::PWR_STOPPING);
  assign pwrBusy = enableReq || (pwr_r != aefa_pkg::PWR_OFF);
  assign driveEnable = driveIfCfg && (pwr_r != aefa_pkg::PWR_OFF);
  assign axisEnabledFlag = statusOn;
  assign brakeRequest = (pwr_r == aefa_pkg::PWR_STOPPING);
  assign jerkLimit = brakeRequest &&
                     (stopSel == aefa_pkg::STOP_EMERG_JERK);
  assign pulseHalt = (pwr_r == aefa_pkg::PWR_OFF) ||
                     (brakeRequest &&
                      stopSel == aefa_pkg::STOP_IMMEDIATE);
  assign stopBehaviourSelect = stopSel;

  // Fault acknowledge task
  assign ackBusy = (ack_r == aefa_pkg::ACK_RUN);
  assign doCopy = reloadSel && (pwr_r == aefa_pkg::PWR_OFF);
  assign ackFinishOk = ackBusy && (ackCnt_r == 4'h0) &&
                       (reloadSel ? doCopy : !cfgFaultCause);
  assign ackFinishErr = ackBusy && (ackCnt_r == 4'h0) && !ackFinishOk;
  assign clearFaults = ackFinishOk && !reloadSel;

  always_comb begin
    ack_nxt = ack_r;
    ackCnt_nxt = ackCnt_r;
    ackDone_nxt = ackDone_r;
    ackError_nxt = ackError_r;
    faultCode_nxt = faultCode_r;
    faultDetail_nxt = faultDetail_r;
    workCfg_nxt = workCfg_r;
    case (ack_r)
      aefa_pkg::ACK_IDLE: begin
        if (launchRise) begin
          ack_nxt = aefa_pkg::ACK_RUN;
          ackCnt_nxt = aefa_pkg::ACK_CNT_LOAD;
          ackDone_nxt = 1'b0;
          ackError_nxt = 1'b0;
          faultCode_nxt = aefa_pkg::CODE_NONE;
          faultDetail_nxt = aefa_pkg::DETAIL_NONE;
        end
      end
      aefa_pkg::ACK_RUN: begin
        // Nothing else can abort a running task
        if (ackCnt_r != 4'h0) begin
          ackCnt_nxt = ackCnt_r - 4'h1;
        end else begin
          ack_nxt = aefa_pkg::ACK_FINISH;
          if (ackFinishOk) begin
            ackDone_nxt = 1'b1;
            if (reloadSel) begin
              workCfg_nxt = loadCfg_r;
            end
          end else begin
            ackError_nxt = 1'b1;
            if (reloadSel) begin
              faultCode_nxt = aefa_pkg::CODE_NOT_DISABLED;
              faultDetail_nxt = aefa_pkg::DETAIL_RELOAD;
            end else begin
              faultCode_nxt = aefa_pkg::CODE_CAUSE_PRESENT;
              faultDetail_nxt = aefa_pkg::DETAIL_CFG_CAUSE;
            end
          end
        end
      end
      aefa_pkg::ACK_FINISH: begin
        ack_nxt = aefa_pkg::ACK_IDLE;
      end
      default: ack_nxt = aefa_pkg::ACK_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r <= aefa_pkg::ACK_IDLE;
      ackCnt_r <= 4'h0;
      ackDone_r <= 1'b0;
      ackError_r <= 1'b0;
      faultCode_r <= aefa_pkg::CODE_NONE;
      faultDetail_r <= aefa_pkg::DETAIL_NONE;
      workCfg_r <= aefa_pkg::CFG_RESET;
    end else begin
      ack_r <= ack_nxt;
      ackCnt_r <= ackCnt_nxt;
      ackDone_r <= ackDone_nxt;
      ackError_r <= ackError_nxt;
      faultCode_r <= faultCode_nxt;
      faultDetail_r <= faultDetail_nxt;
      workCfg_r <= workCfg_nxt;
    end
  end

  assign workConfig = workCfg_r;

  // Fault latches, a new operating fault wins over the clear, the clear wins over a configuration cause
  always_comb begin
    opFault_nxt = opFault_r;
    cfgFault_nxt = cfgFault_r;
    if (clearFaults) begin
      opFault_nxt = 1'b0;
      cfgFault_nxt = 1'b0;
    end
    if (opFaultEvent) begin
      opFault_nxt = 1'b1;
    end
    if (cfgFaultCause && !clearFaults) begin
      cfgFault_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opFault_r <= 1'b0;
      cfgFault_r <= 1'b0;
    end else begin
      opFault_r <= opFault_nxt;
      cfgFault_r <= cfgFault_nxt;
    end
  end

  assign axisFaultFlag = opFault_r || cfgFault_r;

  // Interrupt status, set wins over write-one-to-clear
  always_comb begin
    irqEvent = '0;
    irqEvent[aefa_pkg::IRQ_ENABLED] = (pwr_nxt == aefa_pkg::PWR_ON) &&
                                      (pwr_r != aefa_pkg::PWR_ON);
    irqEvent[aefa_pkg::IRQ_DISABLED] = (pwr_nxt == aefa_pkg::PWR_OFF) &&
                                       statusOn;
    irqEvent[aefa_pkg::IRQ_ACK_DONE] = ackBusy && ackFinishOk;
    irqEvent[aefa_pkg::IRQ_ACK_ERROR] = ackFinishErr;
    irqEvent[aefa_pkg::IRQ_FAULT] = (opFaultEvent && !opFault_r) ||
                                    (cfgFaultCause && !cfgFault_r);
  end

  always_comb begin
    irqStat_nxt = irqStat_r;
    if (wrStrobe && regHit(paddr, aefa_pkg::OFF_IRQ_STAT)) begin
      irqStat_nxt = irqStat_r & ~pwdata[aefa_pkg::IRQ_WIDTH-1:0];
    end
    irqStat_nxt = irqStat_nxt | irqEvent;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= irqStat_nxt;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

endmodule // aefa_axis_enable_ctrl

// >>> hw/aefa_pkg.sv
package aefa_pkg;

  // Clock and task timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACK_TIME_NS = 40;
  localparam int ACK_CYCLES_RAW =
    (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_CYCLES = (ACK_CYCLES_RAW < 1) ? 1 : ACK_CYCLES_RAW;
  localparam logic [3:0] ACK_CNT_LOAD = 4'(ACK_CYCLES - 1);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FAULT = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_LOAD_CFG = 8'h14;
  localparam logic [7:0] OFF_WORK_CFG = 8'h18;

  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_STOP_LSB = 1;
  localparam int CTRL_DRIVE_IF = 3;
  localparam int CTRL_RELOAD = 4;
  localparam int CTRL_LAUNCH = 5;
  localparam int CTRL_WIDTH = 6;

  // Status register fields
  localparam int ST_ENABLED = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_AT_REST = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_ACK_BUSY = 4;
  localparam int ST_ACK_DONE = 5;
  localparam int ST_ACK_ERROR = 6;
  localparam int ST_DRIVE_EN = 7;
  localparam int ST_OP_FAULT = 8;
  localparam int ST_CFG_FAULT = 9;

  // Interrupt event bits
  localparam int IRQ_ENABLED = 0;
  localparam int IRQ_DISABLED = 1;
  localparam int IRQ_ACK_DONE = 2;
  localparam int IRQ_ACK_ERROR = 3;
  localparam int IRQ_FAULT = 4;
  localparam int IRQ_WIDTH = 5;

  // Reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Stop behaviour encoding
  localparam logic [1:0] STOP_EMERGENCY = 2'h0;
  localparam logic [1:0] STOP_IMMEDIATE = 2'h1;
  localparam logic [1:0] STOP_EMERG_JERK = 2'h2;

  // Fault codes reported by a failed acknowledge task
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_NOT_DISABLED = 16'h0001;
  localparam logic [15:0] CODE_CAUSE_PRESENT = 16'h0002;
  localparam logic [15:0] DETAIL_NONE = 16'h0000;
  localparam logic [15:0] DETAIL_RELOAD = 16'h0001;
  localparam logic [15:0] DETAIL_CFG_CAUSE = 16'h0002;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_WAIT_READY = 2'b01,
    PWR_ON = 2'b11,
    PWR_STOPPING = 2'b10
  } aefa_pwr_t;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_RUN = 2'b01,
    ACK_FINISH = 2'b11
  } aefa_ack_t;

endpackage
